// *** sjp_pkg.sv ***
// Package of constants, table image and types for the parameter table store.
`default_nettype none

package sjp_pkg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] SJP_READ_OPCODE = 8'h5a;
  localparam int SJP_PADDR_W = 24;
  localparam logic [23:0] SJP_TABLE_BASE = 24'h000030;
  localparam int SJP_TABLE_DWORDS = 9;
  localparam int SJP_TABLE_BYTES = SJP_TABLE_DWORDS * 4;
  localparam int SJP_IDX_W = 6;
  localparam logic [7:0] SJP_UNUSED_BYTE = 8'hff;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] SJP_OFS_CMD = 8'h00;
  localparam logic [7:0] SJP_OFS_ADDR = 8'h04;
  localparam logic [7:0] SJP_OFS_DATA = 8'h08;
  localparam logic [7:0] SJP_OFS_STATUS = 8'h0c;
  localparam int SJP_ST_CMD_OK = 0;
  localparam int SJP_ST_WR_REJ = 1;
  localparam int SJP_ST_BAD_CMD = 2;
  localparam logic [7:0] SJP_CMD_RST = 8'h00;
  localparam logic [23:0] SJP_ADDR_RST = 24'h000000;
  localparam logic [1:0] SJP_STICKY_RST = 2'h0;
  localparam logic [1:0] SJP_RESP_OKAY = 2'h0;
  localparam logic [1:0] SJP_RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Table image, parameter address 30H upward, one byte per entry.
  localparam logic [7:0] SJP_TABLE [0:SJP_TABLE_BYTES-1] = '{
    {3'h7, 1'b0, 1'b0, 1'b1, 2'h1},
    8'h20,
    {1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 2'h0, 1'b1},
    8'hff,
    8'hff, 8'hff, 8'hff, 8'h07,
    {3'h2, 5'h04}, 8'heb,
    {3'h0, 5'h08}, 8'h6b,
    {3'h0, 5'h08}, 8'h3b,
    {3'h2, 5'h02}, 8'hbb,
    {3'h7, 1'b1, 3'h7, 1'b0},
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
    {3'h0, 5'h00}, 8'hff,
    8'hff, 8'hff,
    {3'h2, 5'h04}, 8'heb,
    8'h0c, 8'h20,
    8'h0f, 8'h52, 8'h10, 8'hd8,
    8'h00, 8'hff
  };

  ////////////////////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    SJP_RD_IDLE = 2'b00,
    SJP_RD_FETCH = 2'b01,
    SJP_RD_LOAD = 2'b10,
    SJP_RD_RESP = 2'b11
  } sjp_rd_state_t;

  typedef enum logic [2:0] {
    SJP_SEL_CMD = 3'b000,
    SJP_SEL_ADDR = 3'b001,
    SJP_SEL_DATA = 3'b010,
    SJP_SEL_STATUS = 3'b011,
    SJP_SEL_NONE = 3'b100
  } sjp_sel_t;

  // Maps a bus byte address to a register; misaligned addresses map to nothing.
  function automatic sjp_sel_t sjp_decode(input logic [7:0] ofs);
    sjp_sel_t sel;
    case (ofs)
      SJP_OFS_CMD: sel = SJP_SEL_CMD;
      SJP_OFS_ADDR: sel = SJP_SEL_ADDR;
      SJP_OFS_DATA: sel = SJP_SEL_DATA;
      SJP_OFS_STATUS: sel = SJP_SEL_STATUS;
      default: sel = SJP_SEL_NONE;
    endcase
    return sel;
  endfunction : sjp_decode

endpackage : sjp_pkg

`default_nettype wire

// *** sjp_rom_if.sv ***
// Interface between the register front end and the table memory.
`default_nettype none

interface sjp_rom_if;
  import sjp_pkg::*;
  logic [SJP_IDX_W-1:0] idx;
  logic [7:0] data;
  modport requester (output idx, input data);
  modport store (input idx, output data);
endinterface : sjp_rom_if

`default_nettype wire

// *** sjp_rom.sv ***
// Fixed table memory with registered read data.
`default_nettype none

module sjp_rom
  import sjp_pkg::*;
#(
  parameter int DEPTH = SJP_TABLE_BYTES
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  sjp_rom_if.store port
);

  generate
    if (DEPTH != SJP_TABLE_BYTES)
    begin : g_bad_depth
      $error("sjp_rom depth must match the table image");
    end
  endgenerate

  logic [7:0] dataReg;
  logic [7:0] dataNext;

  // Contents are constants; there is no write path at all.
  always_comb
  begin
    if (32'(port.idx) < DEPTH)
      dataNext = SJP_TABLE[port.idx];
    else
      dataNext = SJP_UNUSED_BYTE;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      dataReg <= SJP_UNUSED_BYTE;
    else
      dataReg <= dataNext;
  end

  assign port.data = dataReg;

endmodule : sjp_rom

`default_nettype wire

// *** sjp_param_table.sv ***
// AXI4-Lite front end of the discoverable-parameter table store.
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none

// Overview of operation
// - Table readable only under opcode 5AH
// - Table starts 30H, nine 32-bit words
// - Byte 30H E5H, 31H 20H
// - Volatile status bits 3,4 read zero
// - Byte 32H F1H lane support
// - Bytes 38H/39H 44H, EBH
// - Bytes 3AH/3BH 08H, 6BH
// - Bytes 3CH/3DH 08H, 3BH
// - Bytes 3EH/3FH 42H, BBH
// - Byte 40H FEH quad yes dual no
// - Bytes 4AH/4BH 44H, EBH
// - Bytes 46H/47H 00H, FFH
// - Unused fields read all ones
// - Sector size byte is 2^N, 0 absent
// - Sector 1: 0CH, 20H
// - Sectors 2,3: 0FH/52H, 10H/D8H
// - Sector 4 absent: 00H, FFH
module sjp_param_table
  import sjp_pkg::*;
#(
  parameter int AXI_ADDR_W = 8
)
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  if (AXI_ADDR_W < 8)
  begin : g_bad_addr_w
    $error("sjp_param_table needs at least 8 address bits");
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Write channel state.
  logic awGotReg, awGotNext, wGotReg, wGotNext;
  logic [7:0] awOfsReg, awOfsNext, cmdReg, cmdNext;
  logic [31:0] wDataReg, wDataNext;
  logic [3:0] wStrbReg, wStrbNext;
  logic awreadyReg, awreadyNext, wreadyReg, wreadyNext, bvalidReg, bvalidNext;
  logic [1:0] brespReg, brespNext, stickyReg, stickyNext;
  logic [23:0] addrReg, addrNext;
  logic doWrite;
  sjp_sel_t wrSel;

  // Read channel state.
  sjp_rd_state_t rdStateReg, rdStateNext;
  logic arreadyReg, arreadyNext, rvalidReg, rvalidNext, rdCmdOkReg, rdCmdOkNext;
  logic [31:0] rdataReg, rdataNext;
  logic [1:0] rrespReg, rrespNext, stickySet, stickyClr;
  sjp_sel_t rdSelReg, rdSelNext;
  logic [23:0] rdAddrReg, rdAddrNext, rdRel;
  logic inTable, dataReadDone;
  logic [7:0] tableByte;

  sjp_rom_if romPort ();

  sjp_rom #(
    .DEPTH(SJP_TABLE_BYTES)
  ) u_rom (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .port(romPort)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Table addressing: only 30H..53H is held here; anything else reads all ones.
  assign rdRel = rdAddrReg - SJP_TABLE_BASE;
  assign inTable = (rdAddrReg >= SJP_TABLE_BASE) &&
                   (rdAddrReg < SJP_TABLE_BASE + 24'(SJP_TABLE_BYTES));
  assign romPort.idx = inTable ? rdRel[SJP_IDX_W-1:0] : '0;
  assign tableByte = (rdCmdOkReg && inTable) ? romPort.data : SJP_UNUSED_BYTE;

  assign doWrite = awGotReg && wGotReg && !bvalidReg;
  assign wrSel = sjp_decode(awOfsReg);
  assign dataReadDone = rvalidReg && s_axi_rready && (rdSelReg == SJP_SEL_DATA);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Write path: address and data are taken in either order, then the response.
  always_comb
  begin
    awGotNext = awGotReg;
    wGotNext = wGotReg;
    awOfsNext = awOfsReg;
    wDataNext = wDataReg;
    wStrbNext = wStrbReg;
    bvalidNext = bvalidReg;
    brespNext = brespReg;
    cmdNext = cmdReg;
    addrNext = addrReg;
    stickySet = 2'h0;
    stickyClr = 2'h0;
    if (s_axi_awvalid && awreadyReg)
    begin
      awGotNext = 1'b1;
      awOfsNext = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && wreadyReg)
    begin
      wGotNext = 1'b1;
      wDataNext = s_axi_wdata;
      wStrbNext = s_axi_wstrb;
    end
    if (bvalidReg && s_axi_bready)
      bvalidNext = 1'b0;
    if (dataReadDone)
      addrNext = addrReg + 24'h000001;
    if (doWrite)
    begin
      awGotNext = 1'b0;
      wGotNext = 1'b0;
      bvalidNext = 1'b1;
      brespNext = SJP_RESP_OKAY;
      case (wrSel)
        SJP_SEL_CMD:
          if (wStrbReg[0])
            cmdNext = wDataReg[7:0];
        SJP_SEL_ADDR:
          for (int i = 0; i < 3; i++)
          begin
            if (wStrbReg[i])
              addrNext[8*i +: 8] = wDataReg[8*i +: 8];
          end
        SJP_SEL_DATA: stickySet[SJP_ST_WR_REJ-1] = 1'b1;
        SJP_SEL_STATUS:
          if (wStrbReg[0])
            stickyClr = wDataReg[SJP_ST_BAD_CMD:SJP_ST_WR_REJ];
        default: brespNext = SJP_RESP_SLVERR;
      endcase
    end
    if (rdStateReg == SJP_RD_LOAD && rdSelReg == SJP_SEL_DATA && !rdCmdOkReg)
      stickySet[SJP_ST_BAD_CMD-1] = 1'b1;
    // A new event in the same cycle as its clear is kept.
    stickyNext = (stickyReg & ~stickyClr) | stickySet;
    awreadyNext = !awGotNext && !bvalidNext;
    wreadyNext = !wGotNext && !bvalidNext;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      awGotReg <= 1'b0;
      wGotReg <= 1'b0;
      awOfsReg <= 8'h00;
      wDataReg <= 32'h00000000;
      wStrbReg <= 4'h0;
      awreadyReg <= 1'b1;
      wreadyReg <= 1'b1;
      bvalidReg <= 1'b0;
      brespReg <= SJP_RESP_OKAY;
      cmdReg <= SJP_CMD_RST;
      addrReg <= SJP_ADDR_RST;
      stickyReg <= SJP_STICKY_RST;
    end
    else
    begin
      awGotReg <= awGotNext;
      wGotReg <= wGotNext;
      awOfsReg <= awOfsNext;
      wDataReg <= wDataNext;
      wStrbReg <= wStrbNext;
      awreadyReg <= awreadyNext;
      wreadyReg <= wreadyNext;
      bvalidReg <= bvalidNext;
      brespReg <= brespNext;
      cmdReg <= cmdNext;
      addrReg <= addrNext;
      stickyReg <= stickyNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Read path: capture, fetch from the table memory, load, answer.
  always_comb
  begin
    rdStateNext = rdStateReg;
    rdSelNext = rdSelReg;
    rdAddrNext = rdAddrReg;
    rdCmdOkNext = rdCmdOkReg;
    rvalidNext = rvalidReg;
    rdataNext = rdataReg;
    rrespNext = rrespReg;
    case (rdStateReg)
      SJP_RD_IDLE:
      begin
        if (s_axi_arvalid && arreadyReg)
        begin
          rdSelNext = sjp_decode(s_axi_araddr[7:0]);
          rdAddrNext = addrReg;
          rdCmdOkNext = (cmdReg == SJP_READ_OPCODE);
          rdStateNext = SJP_RD_FETCH;
        end
      end
      SJP_RD_FETCH: rdStateNext = SJP_RD_LOAD;
      SJP_RD_LOAD:
      begin
        rrespNext = SJP_RESP_OKAY;
        case (rdSelReg)
          SJP_SEL_CMD: rdataNext = {24'h000000, cmdReg};
          SJP_SEL_ADDR: rdataNext = {8'h00, addrReg};
          SJP_SEL_DATA: rdataNext = {24'h000000, tableByte};
          SJP_SEL_STATUS: rdataNext = {29'h00000000, stickyReg, cmdReg == SJP_READ_OPCODE};
          default:
          begin
            rdataNext = 32'h00000000;
            rrespNext = SJP_RESP_SLVERR;
          end
        endcase
        rvalidNext = 1'b1;
        rdStateNext = SJP_RD_RESP;
      end
      SJP_RD_RESP:
      begin
        if (s_axi_rready)
        begin
          rvalidNext = 1'b0;
          rdStateNext = SJP_RD_IDLE;
        end
      end
      default: rdStateNext = SJP_RD_IDLE;
    endcase
    arreadyNext = (rdStateNext == SJP_RD_IDLE);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rdStateReg <= SJP_RD_IDLE;
      rdSelReg <= SJP_SEL_NONE;
      rdAddrReg <= SJP_ADDR_RST;
      rdCmdOkReg <= 1'b0;
      arreadyReg <= 1'b1;
      rvalidReg <= 1'b0;
      rdataReg <= 32'h00000000;
      rrespReg <= SJP_RESP_OKAY;
    end
    else
    begin
      rdStateReg <= rdStateNext;
      rdSelReg <= rdSelNext;
      rdAddrReg <= rdAddrNext;
      rdCmdOkReg <= rdCmdOkNext;
      arreadyReg <= arreadyNext;
      rvalidReg <= rvalidNext;
      rdataReg <= rdataNext;
      rrespReg <= rrespNext;
    end
  end

  assign s_axi_awready = awreadyReg;
  assign s_axi_wready = wreadyReg;
  assign s_axi_bvalid = bvalidReg;
  assign s_axi_bresp = brespReg;
  assign s_axi_arready = arreadyReg;
  assign s_axi_rvalid = rvalidReg;
  assign s_axi_rdata = rdataReg;
  assign s_axi_rresp = rrespReg;

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks on table contents and read sequencing.
  logic arData;
  assign arData = s_axi_arvalid && s_axi_arready &&
                  (sjp_decode(s_axi_araddr[7:0]) == SJP_SEL_DATA) &&
                  (cmdReg == SJP_READ_OPCODE);

  property p_byte30;
    arData && addrReg == 24'h000030 |-> ##3 s_axi_rvalid && s_axi_rdata == 32'h000000e5;
  endproperty
  a_byte30: assert property (p_byte30) else $error("byte 30H wrong");
  property p_byte32;
    arData && addrReg == 24'h000032 |-> ##3 s_axi_rvalid && s_axi_rdata[7:0] == 8'hf1;
  endproperty
  a_byte32: assert property (p_byte32) else $error("byte 32H wrong");
  property p_byte38;
    arData && addrReg == 24'h000038 |-> ##3 s_axi_rvalid && s_axi_rdata[7:0] == 8'h44;
  endproperty
  a_byte38: assert property (p_byte38) else $error("byte 38H wrong");
  property p_byte40;
    arData && addrReg == 24'h000040 |-> ##3 s_axi_rvalid && s_axi_rdata[7:0] == 8'hfe;
  endproperty
  a_byte40: assert property (p_byte40) else $error("byte 40H wrong");
  property p_byte52;
    arData && addrReg == 24'h000052 |-> ##3 s_axi_rvalid && s_axi_rdata[7:0] == 8'h00;
  endproperty
  a_byte52: assert property (p_byte52) else $error("byte 52H wrong");
  property p_badCmd;
    s_axi_arvalid && s_axi_arready && cmdReg != SJP_READ_OPCODE &&
    sjp_decode(s_axi_araddr[7:0]) == SJP_SEL_DATA
    |-> ##3 s_axi_rvalid && s_axi_rdata[7:0] == 8'hff && stickyReg[1];
  endproperty
  a_badCmd: assert property (p_badCmd) else $error("foreign opcode read table data");
  property p_advance;
    dataReadDone && !(doWrite && wrSel == SJP_SEL_ADDR) |=> addrReg == $past(addrReg) + 24'h1;
  endproperty
  a_advance: assert property (p_advance) else $error("address did not advance");
  property p_wrReject;
    doWrite && wrSel == SJP_SEL_DATA |=> stickyReg[0] && s_axi_bvalid;
  endproperty
  a_wrReject: assert property (p_wrReject) else $error("table write not flagged");
  property p_rvalidHold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalidHold: assert property (p_rvalidHold) else $error("read answer dropped");

endmodule : sjp_param_table

`default_nettype wire

// *** sjp_host_model.sv ***
// AXI4-Lite master model standing in for the host that reads the parameter table.
`default_nettype none

module sjp_host_model
(
  input wire logic refClk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 100ps;

  // A nonzero value holds rready low for that many cycles after rvalid is seen.
  int rreadyDelay = 0;

  initial
  begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Address and data are offered together; each is released at its own handshake edge.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    bit awDone;
    bit wDone;
    awDone = 0;
    wDone = 0;
    @(posedge refClk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge refClk);
      if (!awDone && awready === 1'b1)
      begin
        awDone = 1;
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (!wDone && wready === 1'b1)
      begin
        wDone = 1;
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge refClk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge refClk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (rreadyDelay == 0);
    do
      @(posedge refClk);
    while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr <= ~a;
    while (rvalid !== 1'b1)
      @(posedge refClk);
    if (rreadyDelay != 0)
    begin
      repeat (rreadyDelay) @(posedge refClk);
      rready <= 1'b1;
      @(posedge refClk);
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

endmodule : sjp_host_model

`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the parameter table store.
`default_nettype none

module testbench
  import sjp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic refClk;
  logic rstB;
  logic [7:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [7:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  int failCount = 0;
  int nCompared = 0;
  logic [7:0] expTable [0:35] = '{
    8'he5, 8'h20, 8'hf1, 8'hff,
    8'hff, 8'hff, 8'hff, 8'h07,
    8'h44, 8'heb, 8'h08, 8'h6b,
    8'h08, 8'h3b, 8'h42, 8'hbb,
    8'hfe, 8'hff, 8'hff, 8'hff,
    8'hff, 8'hff, 8'h00, 8'hff,
    8'hff, 8'hff, 8'h44, 8'heb,
    8'h0c, 8'h20, 8'h0f, 8'h52,
    8'h10, 8'hd8, 8'h00, 8'hff
  };

  sjp_param_table uut (.ref_clk(refClk), .rst_b(rstB), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  sjp_host_model host (.refClk(refClk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  initial
  begin
    refClk = 1'b0;
    forever #50 refClk = ~refClk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic [1:0] resp;
    host.axi_write(a, d, s, resp);
    check({30'h0, resp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] resp;
    host.axi_read(a, d, resp);
    check(d, ed);
    check({30'h0, resp}, {30'h0, er});
  endtask : rd

  task automatic resetDut();
    rstB <= 1'b0;
    repeat (4) @(posedge refClk);
    rstB <= 1'b1;
    @(posedge refClk);
  endtask : resetDut

  task automatic stopTest();
    $display("comparisons %0d, mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stopTest

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge refClk);
    failCount++;
    stopTest();
  end

  initial
  begin
    resetDut();
    rd(SJP_OFS_CMD, 32'h0, SJP_RESP_OKAY);
    rd(SJP_OFS_ADDR, 32'h0, SJP_RESP_OKAY);
    rd(SJP_OFS_STATUS, 32'h0, SJP_RESP_OKAY);
    wr(SJP_OFS_ADDR, 32'h30, 4'hf, SJP_RESP_OKAY);
    rd(SJP_OFS_DATA, 32'hff, SJP_RESP_OKAY);
    rd(SJP_OFS_STATUS, 32'h4, SJP_RESP_OKAY);
    wr(SJP_OFS_CMD, 32'h5a, 4'h1, SJP_RESP_OKAY);
    wr(SJP_OFS_STATUS, 32'h4, 4'h1, SJP_RESP_OKAY);
    rd(SJP_OFS_STATUS, 32'h1, SJP_RESP_OKAY);
    wr(SJP_OFS_ADDR, 32'h30, 4'hf, SJP_RESP_OKAY);
    for (int i = 0; i < 36; i++)
      rd(SJP_OFS_DATA, {24'h0, expTable[i]}, SJP_RESP_OKAY);
    rd(SJP_OFS_DATA, 32'hff, SJP_RESP_OKAY);
    wr(SJP_OFS_ADDR, 32'h2f, 4'hf, SJP_RESP_OKAY);
    rd(SJP_OFS_DATA, 32'hff, SJP_RESP_OKAY);
    rd(SJP_OFS_DATA, 32'he5, SJP_RESP_OKAY);
    wr(SJP_OFS_DATA, 32'h0, 4'hf, SJP_RESP_OKAY);
    rd(SJP_OFS_STATUS, 32'h3, SJP_RESP_OKAY);
    rd(SJP_OFS_ADDR, 32'h31, SJP_RESP_OKAY);
    wr(SJP_OFS_ADDR, 32'h00abcd4c, 4'h1, SJP_RESP_OKAY);
    rd(SJP_OFS_ADDR, 32'h4c, SJP_RESP_OKAY);
    host.rreadyDelay = 2;
    rd(SJP_OFS_DATA, 32'h0c, SJP_RESP_OKAY);
    rd(SJP_OFS_DATA, 32'h20, SJP_RESP_OKAY);
    host.rreadyDelay = 0;
    wr(SJP_OFS_ADDR, 32'h30, 4'hf, SJP_RESP_OKAY);
    rd(SJP_OFS_DATA, 32'he5, SJP_RESP_OKAY);
    rd(8'h10, 32'h0, SJP_RESP_SLVERR);
    rd(8'h05, 32'h0, SJP_RESP_SLVERR);
    wr(8'h10, 32'hffffffff, 4'hf, SJP_RESP_SLVERR);
    wr(SJP_OFS_CMD, 32'h03, 4'h1, SJP_RESP_OKAY);
    rd(SJP_OFS_STATUS, 32'h2, SJP_RESP_OKAY);
    rd(SJP_OFS_DATA, 32'hff, SJP_RESP_OKAY);
    wr(SJP_OFS_STATUS, 32'h6, 4'h1, SJP_RESP_OKAY);
    rd(SJP_OFS_STATUS, 32'h0, SJP_RESP_OKAY);
    wr(SJP_OFS_CMD, 32'h5a, 4'h1, SJP_RESP_OKAY);
    resetDut();
    rd(SJP_OFS_CMD, 32'h0, SJP_RESP_OKAY);
    rd(SJP_OFS_ADDR, 32'h0, SJP_RESP_OKAY);
    stopTest();
  end

endmodule : testbench

`default_nettype wire
